/* File: bench/host_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ====================================================
// host side: serial irq controller and clock resource
module host_model (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // bench commands
  input wire logic go,
  input wire logic stop_req,
  // line levels, pulls and the captured frame
  input wire logic ser_line,
  output logic ser_pull,
  output logic clk_pull,
  output logic [79:0] mask,
  output logic done
);
  int n = 0;

  // start low 4 cycles, listen 80, stop low 3, then idle
  always @(posedge clock) begin
    if (!rst_n) begin
      n <= 0;
      done <= 1'b0;
      mask <= '0;
    end else if (n == 0) begin
      if (go) begin
        n <= 1;
        done <= 1'b0;
        mask <= '0;
      end
    end else begin
      n <= (n == 88) ? 0 : n + 1;
      if (n >= 5 && n < 85) begin
        mask[n-5] <= ~ser_line;
      end
      if (n == 88) begin
        done <= 1'b1;
      end
    end
  end

  // start and stop cycles are ours, slots belong to the device
  assign ser_pull = (n >= 1 && n < 5) || (n >= 85 && n < 88);
  // the clock stays asserted low unless a stop is asked for
  assign clk_pull = ~stop_req;
endmodule
`default_nettype wire

/* File: bench/tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
  import card_irq_pkg::*;
  // ====================================================
  // stimulus and wiring
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  apb_req_s apb = '0;
  card_pins_s card_pins = '0;
  logic [1:0] power_change = 2'h0;
  bridge_busy_s busy = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [6:0] term_i;
  logic [6:0] term_oe;
  logic [6:0] term_o;
  logic ser_i;
  logic ser_o;
  logic ser_oe;
  logic ser_pull;
  logic clk_pull;
  logic go = 1'b0;
  logic stop_req = 1'b0;
  logic done;
  logic seen;
  logic e;
  logic [79:0] mask;
  logic [31:0] q;
  logic [31:0] rs = 32'h44;
  int failures = 0;
  int compares = 0;
  int cyc = 0;
  int c;
  int s;
  int k;
  int n;
  localparam logic [31:0] RT = 32'h1 << ROUTE_BIT;
  localparam logic [31:0] EN = 32'h1 << ENB_BIT;
  localparam logic [31:0] PD = 32'h1 << PEND_BIT;

  always #25 clock = ~clock;
  // open drain lines with pull-ups; terminal 6 also pulled by host
  assign term_i = ~term_oe & {~clk_pull, 6'h3F};
  assign ser_i = ser_oe ? ser_o : ~ser_pull;

  card_bridge_interrupt_routing #(.CLKRUN_DRIVE(2)) dut_u (
    .clock(clock), .rst_n(rst_n), .apb(apb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .card_pins(card_pins),
    .power_change(power_change), .busy(busy),
    .multifunction_terminals_i(term_i),
    .multifunction_terminals_o(term_o),
    .multifunction_terminals_oe(term_oe),
    .serirq_i(ser_i), .serirq_o(ser_o), .serirq_oe(ser_oe));

  host_model host_u (
    .clock(clock), .rst_n(rst_n), .go(go), .stop_req(stop_req),
    .ser_line(ser_i), .ser_pull(ser_pull), .clk_pull(clk_pull),
    .mask(mask), .done(done));

  // ====================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic conclude();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic idle(input int cnt);
    repeat (cnt) @(posedge clock);
  endtask

  // one apb transfer; the request holds until pready is seen
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge clock);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clock);
    apb.penable <= 1'b1;
    // no wait count here: only the hang guard may end this wait
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    apb <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] x);
    xfer(1'b0, a, 32'h0);
    check(q & m, x);
  endtask

  task automatic pulse(input logic [1:0] p);
    @(posedge clock);
    power_change <= p;
    @(posedge clock);
    power_change <= 2'h0;
  endtask

  // run one host frame, count low slots and first-to-last spacing
  task automatic frame();
    int f;
    f = -1;
    c = 0;
    s = 0;
    @(posedge clock);
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    // done of the last frame still reads high at this edge; skip it
    do begin
      @(posedge clock);
    end while (done !== 1'b1);
    for (int i = 0; i < 80; i++) begin
      if (mask[i] === 1'b1) begin
        c++;
        f = (f < 0) ? i : f;
        s = i - f;
      end
    end
    idle(80);
  endtask

  task automatic watch();
    seen = 1'b0;
    repeat (12) begin
      @(posedge clock);
      seen = seen | (term_oe[6] === 1'b1);
    end
  endtask

  // hang guard: the whole sequence needs about 1200 cycles
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      conclude();
    end
  end

  // ====================================================
  // main sequence
  initial begin
    idle(12);
    rst_n <= 1'b1;
    idle(4);
    rd_chk(DEVCTL_OFS, 32'h6, 32'h6);
    rd_chk(INTERRUPT_PIN_VALUE_F0_OFS, 32'hFFFFFFFF, 32'h1);
    rd_chk(INTERRUPT_PIN_VALUE_F1_OFS, 32'hFFFFFFFF, 32'h2);
    xfer(1'b0, 8'h24, 32'h0);
    check({31'h0, e}, 32'h1);
    for (k = 0; k < 3; k++) begin
      rs = lfsr(rs);
      wr(MFROUTE_F1_OFS, rs & 32'h0FFFFFFF);
      rd_chk(MFROUTE_F0_OFS, 32'hFFFFFFFF, rs & 32'h0FFFFFFF);
    end
    // parallel pci lines, then tied onto the first line
    wr(DEVCTL_OFS, 32'h0);
    wr(MFROUTE_F0_OFS, 32'h22);
    wr(IRQSEL_OFS, 32'h100);
    card_pins.card_irq <= 2'b10;
    idle(8);
    check({25'h0, term_oe}, 32'h2);
    rd_chk(STATUS_OFS, 32'h3, 32'h2);
    wr(SYSCTRL_F0_OFS, 32'h1 << TIE_BIT);
    idle(4);
    check({25'h0, term_oe}, 32'h1);
    rd_chk(STATUS_OFS, 32'h3, 32'h1);
    for (k = 0; k < 4; k++) begin
      wr(DEVCTL_OFS, k << MODE_LSB);
      rd_chk(INTERRUPT_PIN_VALUE_F1_OFS, 32'hFF, 32'h1);
    end
    wr(SYSCTRL_F0_OFS, 32'h0);
    rd_chk(INTERRUPT_PIN_VALUE_F1_OFS, 32'hFF, 32'h2);
    // parallel isa irq on random selectors per terminal
    wr(DEVCTL_OFS, 32'h2);
    card_pins.card_irq <= 2'b01;
    for (k = 2; k < 6; k++) begin
      rs = lfsr(rs);
      n = 3 + rs % 13;
      wr(IRQSEL_OFS, n);
      wr(MFROUTE_F0_OFS, 32'h2 | (n << (4 * k)));
      idle(4);
      check({25'h0, term_oe}, 32'h1 << k);
    end
    // maintenance interrupt: gate, route, per-socket pending
    card_pins.card_irq <= 2'b00;
    wr(MFROUTE_F0_OFS, 32'h2202);
    wr(SYSCTRL_F0_OFS, RT);
    pulse(2'b01);
    rd_chk(STATUS_OFS, 32'h1C, 32'h0);
    wr(SYSCTRL_F0_OFS, RT | EN);
    pulse(2'b01);
    rd_chk(STATUS_OFS, 32'h1C, 32'h0C);
    check({25'h0, term_oe & 7'h0C}, 32'h8);
    wr(SYSCTRL_F1_OFS, RT | EN | PD);
    wr(SYSCTRL_F0_OFS, RT | EN);
    rd_chk(STATUS_OFS, 32'h1C, 32'h0C);
    pulse(2'b10);
    rd_chk(STATUS_OFS, 32'h18, 32'h18);
    // serial frames: irq2 slot plus inta slot only in mode 3
    wr(IRQSEL_OFS, 32'h100);
    card_pins.card_irq <= 2'b01;
    wr(DEVCTL_OFS, 32'h6);
    frame();
    check(c, 2);
    check(s, 45);
    wr(DEVCTL_OFS, 32'h4);
    frame();
    check(c, 1);
    card_pins.card_irq <= 2'b00;
    wr(SYSCTRL_F0_OFS, PD);
    wr(SYSCTRL_F1_OFS, PD);
    rd_chk(STATUS_OFS, 32'h1C, 32'h0);
    frame();
    check(c, 0);
    // status change in edge mode gives a single cycle on terminal 0
    wr(IRQSEL_OFS, 32'h200);
    card_pins.card_status <= 2'b01;
    c = 0;
    repeat (12) begin
      @(posedge clock);
      c += (term_oe[0] === 1'b1);
    end
    check(c, 1);
    card_pins.card_status <= 2'b00;
    // clock run: refuse or restart on every single cause
    wr(MFROUTE_F0_OFS, 32'h1000000);
    check({25'h0, term_o}, 32'h0);
    stop_req <= 1'b1;
    watch();
    check({31'h0, seen}, 32'h0);
    for (k = 0; k < 17; k++) begin
      {busy, card_pins} <= 17'h1 << k;
      watch();
      check({31'h0, seen}, 32'h1);
      {busy, card_pins} <= '0;
      idle(12);
    end
    wr(SYSCTRL_F0_OFS, 32'h1 << HOLD_BIT);
    watch();
    check({31'h0, seen}, 32'h1);
    conclude();
  end
endmodule
`default_nettype wire

/* File: logic/card_bridge_interrupt_routing.sv */
// Functional notes
// (R1) host picks parallel irq mode, then fills the terminal routing register
// (R2) parallel irq systems put inta on terminal 0, six irqs remain
// (R3) one routing register shared by both functions' views
// (R4) software should write routing through function 0 only
// (R5) 4-bit selector per terminal; 3..15 isa irq, 2 on terminal 0 inta
// (R6) inta can drive terminal 0, intb terminal 1
// (R7) tie bit 29 puts both sockets onto inta
// (R8) interrupt pin reads 01/02, or 01/01 when tied
// (R9) reset mode serializes both isa and pci interrupts
// (R10) serial packet: start, indication slots, stop, on pci clock
// (R11) packet carries sixteen isa irqs and four pci lines; only inta and intb are sent here, slots 19-20 stay zero
// (R12) power change write with enable raises a maintenance interrupt
// (R13) route bit 26, pending bit 25, enable bit 24
// (R14) shared route bit picks status change or irq2 delivery
// (R15) per-socket pending flag, cleared only by writing one
// (R16) shared enable gates maintenance interrupt generation
// (R17) status change delivery per socket, level or edge by mode bit
// (R18) irq2 uses serial slot 2; parallel only on terminals 3 or 6
// (R19) clock-run signalling lives on terminal 6
// (R20) refuse clock stop while hold, busy, pending or card clock runs
// (R21) request clock restart on card irq, wake, clock, bus or dma request
//
// Added by the designer: register access over APB and the address map.
`timescale 1ns/1ns
`default_nettype none
module card_bridge_interrupt_routing
  import card_irq_pkg::*;
#(
  parameter int unsigned CLKRUN_DRIVE = CLKRUN_DRIVE_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // apb slave
  input wire apb_req_s apb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // card side pins and bridge state
  input wire card_pins_s card_pins,
  input wire logic [1:0] power_change,
  input wire bridge_busy_s busy,
  // multifunction terminals, open drain
  input wire logic [6:0] multifunction_terminals_i,
  output logic [6:0] multifunction_terminals_o,
  output logic [6:0] multifunction_terminals_oe,
  // serialized interrupt line, open drain plus recovery drive
  input wire logic serirq_i,
  output logic serirq_o,
  output logic serirq_oe
);

  // ==========================================================
  // parameter check
  if (CLKRUN_DRIVE < 1 || CLKRUN_DRIVE > 15) begin : g_chk
    $error("CLKRUN_DRIVE must lie in 1..15");
  end

  localparam logic [3:0] DRIVE_CNT = CLKRUN_DRIVE[3:0];
  localparam int unsigned SYNC_W = $bits(card_pins_s) + 2;

  function automatic logic [15:0] irq_onehot(input logic [3:0] n,
                                             input logic en);
    irq_onehot = en ? (16'h0001 << n) : 16'h0000;
  endfunction

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // pin synchronisers: a change counts once stages 2 and 3 agree
  logic [SYNC_W-1:0] s1_q, s2_q, s3_q, filt_q;
  wire [SYNC_W-1:0] pins_raw = {serirq_i,
    multifunction_terminals_i[TERM_CLKRUN], card_pins};
  wire [SYNC_W-1:0] filt_d = (s2_q & s3_q) | ((s2_q ^ s3_q) & filt_q);

  always_ff @(posedge clock) begin
    s1_q <= pins_raw;
    s2_q <= s1_q;
    s3_q <= s2_q;
    // idle levels: pulled-up lines high, card pins low, so no false edge
    if (!rst_n) begin
      filt_q <= {2'b11, {(SYNC_W-2){1'b0}}};
    end else begin
      filt_q <= filt_d;
    end
  end

  card_pins_s cp;
  wire serirq_line = filt_q[SYNC_W-1];
  wire clkrun_line = filt_q[SYNC_W-2];
  assign cp = filt_q[SYNC_W-3:0];

  // ==========================================================
  // register file
  logic tie_q, route_q, enb_q, hold_q;
  logic [1:0] pend_q, pend_d;
  logic [27:0] mfroute_q;
  sig_mode_e mode_q;
  logic [9:0] irqsel_q;

  // apb decode; a write lands in the access cycle only
  wire setup = apb.psel & ~apb.penable;
  wire wr = apb.psel & apb.penable & apb.pwrite & pready;
  wire wr_sys0 = wr && apb.paddr == SYSCTRL_F0_OFS;
  wire wr_sys1 = wr && apb.paddr == SYSCTRL_F1_OFS;
  wire wr_sys = wr_sys0 | wr_sys1;
  wire wr_mf = wr && (apb.paddr == MFROUTE_F0_OFS ||
                      apb.paddr == MFROUTE_F1_OFS); // see R3
  wire wr_dev = wr && apb.paddr == DEVCTL_OFS;
  wire wr_sel = wr && apb.paddr == IRQSEL_OFS;
  wire [1:0] pend_clr = {wr_sys1, wr_sys0} & {2{apb.pwdata[PEND_BIT]}};
  wire [1:0] pend_set = power_change & {2{enb_q}}; // see R12 see R16
  // a power change in the clearing cycle keeps the flag set
  assign pend_d = pend_set | (pend_q & ~pend_clr); // see R15

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tie_q <= 1'b0;
      route_q <= 1'b0;
      enb_q <= 1'b0;
      hold_q <= 1'b0;
      pend_q <= 2'b00;
      mfroute_q <= MFROUTE_RST;
      mode_q <= MODE_SER_ALL; // see R9
      irqsel_q <= IRQSEL_RST;
    end else begin
      pend_q <= pend_d;
      if (wr_sys) begin
        tie_q <= apb.pwdata[TIE_BIT]; // see R7
        route_q <= apb.pwdata[ROUTE_BIT]; // see R13 see R14
        enb_q <= apb.pwdata[ENB_BIT]; // see R13
        hold_q <= apb.pwdata[HOLD_BIT];
      end
      if (wr_mf) begin
        mfroute_q <= apb.pwdata[27:0];
      end
      if (wr_dev) begin
        mode_q <= sig_mode_e'(apb.pwdata[MODE_LSB +: 2]); // see R1
      end
      if (wr_sel) begin
        irqsel_q <= apb.pwdata[9:0];
      end
    end
  end

  // ==========================================================
  // mode decode
  wire isa_par = mode_q == MODE_PAR_ISA;
  wire pci_par = mode_q != MODE_SER_ALL;
  wire ser_isa = mode_q == MODE_SER_ISA || mode_q == MODE_SER_ALL;
  wire ser_pci = mode_q == MODE_SER_ALL;
  wire fpci = irqsel_q[FPCI_BIT];
  wire csc_edge_mode = irqsel_q[STATUS_CHANGE_SIGNAL_MODE_BIT];

  // ==========================================================
  // interrupt sources
  logic [1:0] csc_prev_q;
  // maintenance interrupts join status change unless sent as irq2
  wire [1:0] csc_lvl = cp.card_status | (pend_q & {2{~route_q}});
  wire [1:0] csc_int = csc_edge_mode ? (csc_lvl & ~csc_prev_q)
                                     : csc_lvl; // see R17
  wire irq2 = route_q & (|pend_q); // see R14
  wire [1:0] func_pci = cp.card_irq & {2{fpci}};
  wire [1:0] sock_int = csc_int | func_pci;
  wire inta = sock_int[0] | (tie_q & sock_int[1]); // see R7 see R2
  wire intb = ~tie_q & sock_int[1];
  wire [15:0] isa_irq =
    irq_onehot(irqsel_q[SELA_LSB +: 4], cp.card_irq[0] & ~fpci) |
    irq_onehot(irqsel_q[SELB_LSB +: 4], cp.card_irq[1] & ~fpci) |
    irq_onehot(IRQ2_NUM, irq2);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      csc_prev_q <= 2'b00;
    end else begin
      csc_prev_q <= csc_lvl;
    end
  end

  // ==========================================================
  // clock-run: hold off a stop, or request a restart
  logic [3:0] ckr_cnt_q;
  wire clkrun_en = mfroute_q[4*TERM_CLKRUN +: 4] == SEL_CLKRUN; // see R19
  wire int_pending = inta | intb | (|isa_irq);
  wire keep_clk = hold_q | busy.legacy_busy | busy.cb_master_busy |
    busy.pci_master_busy | (|busy.cclk_running) | int_pending; // see R20
  wire restart = |{cp.card_irq, cp.card_wake, cp.card_status,
    cp.card_clock_run, cp.card_bus_req, cp.card_dma_req}; // see R21
  wire clkrun_drive = ckr_cnt_q != 4'h0;
  wire ckr_start = clkrun_en & clkrun_line & (keep_clk | restart);

  // line high means stop requested or clock stopped; pull it low
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ckr_cnt_q <= 4'h0;
    end else if (clkrun_drive) begin
      ckr_cnt_q <= ckr_cnt_q - 4'h1;
    end else if (ckr_start) begin
      ckr_cnt_q <= DRIVE_CNT;
    end
  end

  // ==========================================================
  // parallel terminal routing, active low open drain
  logic [NUM_TERM-1:0] term_act;
  for (genvar t = 0; t < NUM_TERM; t++) begin : g_term
    wire [3:0] sel = mfroute_q[4*t +: 4]; // see R5
    wire pci_hit = sel == SEL_PCI && pci_par &&
      ((t == TERM_INTA && inta) || (t == TERM_INTB && intb)); // see R6
    wire isa_hit = isa_par && sel >= SEL_ISA_MIN && isa_irq[sel];
    wire irq2_hit = isa_par && sel == SEL_PCI && irq2 &&
      (t == TERM_IRQ2_LO || t == TERM_IRQ2_HI); // see R18
    wire ckr_hit = t == TERM_CLKRUN && sel == SEL_CLKRUN &&
      clkrun_drive;
    assign term_act[t] = pci_hit | isa_hit | irq2_hit | ckr_hit;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      multifunction_terminals_o <= '0;
      multifunction_terminals_oe <= '0;
    end else begin
      multifunction_terminals_o <= '0;
      multifunction_terminals_oe <= term_act;
    end
  end

  // ==========================================================
  // serialized interrupt frames, continuous mode, host starts
  typedef enum logic [1:0] {
    SER_IDLE,
    SER_START,
    SER_TURN,
    SER_SLOT
  } ser_state_e;

  ser_state_e ser_q, ser_d;
  logic [4:0] slot_q, slot_d;
  logic [1:0] ph_q, ph_d;
  // slots 0-15 isa, 16 unused, 17-18 inta and intb, 19-20 always zero
  wire [20:0] ser_bits = {2'b00, intb & ser_pci, inta & ser_pci, 1'b0,
    isa_irq & {16{ser_isa}}}; // see R11 see R18
  wire ser_oe_d = ser_q == SER_SLOT && ph_q != PH_TURN &&
    ser_bits[slot_q];

  always_comb begin
    ser_d = ser_q;
    slot_d = slot_q;
    ph_d = ph_q;
    case (ser_q) // see R10
      SER_IDLE: begin
        if (ser_isa && !serirq_line) begin
          ser_d = SER_START;
        end
      end
      SER_START: begin
        if (serirq_line) begin
          ser_d = SER_TURN;
        end
      end
      SER_TURN: begin
        ser_d = SER_SLOT;
        slot_d = 5'h00;
        ph_d = PH_SAMPLE;
      end
      default: begin
        if (ph_q != PH_TURN) begin
          ph_d = ph_q + 2'h1;
        end else if (slot_q == SLOT_LAST) begin
          ser_d = SER_IDLE; // stop frame belongs to the host
        end else begin
          slot_d = slot_q + 5'h01;
          ph_d = PH_SAMPLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ser_q <= SER_IDLE;
      slot_q <= 5'h00;
      ph_q <= PH_SAMPLE;
      serirq_o <= 1'b1;
      serirq_oe <= 1'b0;
    end else begin
      ser_q <= ser_d;
      slot_q <= slot_d;
      ph_q <= ph_d;
      serirq_o <= ph_q == PH_RECOV; // low in sample, high in recovery
      serirq_oe <= ser_oe_d;
    end
  end

  // ==========================================================
  // read mux and apb answer
  function automatic logic [31:0] sys_word(input logic pend);
    sys_word = '0;
    sys_word[TIE_BIT] = tie_q;
    sys_word[ROUTE_BIT] = route_q;
    sys_word[PEND_BIT] = pend;
    sys_word[ENB_BIT] = enb_q;
    sys_word[HOLD_BIT] = hold_q;
  endfunction

  logic [31:0] rdata_d;
  logic hit;
  always_comb begin
    rdata_d = '0;
    hit = 1'b1;
    if (apb.paddr == SYSCTRL_F0_OFS) begin
      rdata_d = sys_word(pend_q[0]);
    end else if (apb.paddr == SYSCTRL_F1_OFS) begin
      rdata_d = sys_word(pend_q[1]);
    end else if (apb.paddr == MFROUTE_F0_OFS ||
                 apb.paddr == MFROUTE_F1_OFS) begin
      rdata_d[27:0] = mfroute_q;
    end else if (apb.paddr == DEVCTL_OFS) begin
      rdata_d[MODE_LSB +: 2] = mode_q;
    end else if (apb.paddr == INTERRUPT_PIN_VALUE_F0_OFS) begin
      rdata_d[7:0] = INTERRUPT_PIN_VALUE_A; // see R8
    end else if (apb.paddr == INTERRUPT_PIN_VALUE_F1_OFS) begin
      rdata_d[7:0] = tie_q ? INTERRUPT_PIN_VALUE_A : INTERRUPT_PIN_VALUE_B; // see R8
    end else if (apb.paddr == IRQSEL_OFS) begin
      rdata_d[9:0] = irqsel_q;
    end else if (apb.paddr == STATUS_OFS) begin
      rdata_d[ST_INTA] = inta;
      rdata_d[ST_INTB] = intb;
      rdata_d[ST_IRQ2] = irq2;
      rdata_d[ST_PEND_LSB +: 2] = pend_q;
      rdata_d[ST_CLKRUN] = clkrun_drive;
      rdata_d[ST_SER] = ser_q != SER_IDLE;
    end else begin
      hit = 1'b0;
    end
  end

  // data is captured in the setup cycle, so access lasts one cycle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= rdata_d;
      pready <= setup;
      pslverr <= setup & ~hit;
    end
  end

  // ==========================================================
  // checks
  a_pend_set: assert property ( // see R12
    enb_q && power_change[0] |=> pend_q[0])
    else $error("pending flag missed a power change");
  a_pend_sticky: assert property ( // see R15
    pend_q[1] && !(wr_sys1 && apb.pwdata[PEND_BIT]) |=> pend_q[1])
    else $error("pending flag dropped without a write of one");
  a_enable_gate: assert property ( // see R16
    !enb_q && !pend_q[0] && !(wr_sys && apb.pwdata[ENB_BIT])
      |=> !pend_q[0])
    else $error("pending flag set while disabled");
  a_interrupt_pin_value_tied: assert property ( // see R8
    setup && apb.paddr == INTERRUPT_PIN_VALUE_F1_OFS && tie_q && !wr_sys
      |=> prdata[7:0] == INTERRUPT_PIN_VALUE_A)
    else $error("interrupt pin value wrong while tied");
  a_route_shared: assert property ( // see R3
    wr && apb.paddr == MFROUTE_F1_OFS |=>
      mfroute_q == $past(apb.pwdata[27:0]))
    else $error("routing write through function 1 lost");
  a_inta_term0: assert property ( // see R6
    pci_par && mfroute_q[3:0] == SEL_PCI && inta
      |=> multifunction_terminals_oe[TERM_INTA])
    else $error("inta not driven on terminal 0");
  a_irq2_slot: assert property ( // see R18
    ser_q == SER_SLOT && slot_q == 5'h02 && ph_q == PH_SAMPLE &&
    irq2 && ser_isa |=> serirq_oe && !serirq_o)
    else $error("irq2 slot not driven");
  a_keep_clock: assert property ( // see R20
    ckr_start && !clkrun_drive |=>
      ckr_cnt_q != 4'h0 ##1 multifunction_terminals_oe[TERM_CLKRUN])
    else $error("clock stop not refused");
  a_reset_mode: assert property ( // see R9
    $rose(rst_n) |-> mode_q == MODE_SER_ALL)
    else $error("reset mode is not fully serialized");

endmodule
`default_nettype wire

/* File: logic/card_irq_pkg.sv */
package card_irq_pkg;

  // ==========================================================
  // register map (byte addresses on the apb bus)
  localparam logic [7:0] SYSCTRL_F0_OFS = 8'h00;
  localparam logic [7:0] SYSCTRL_F1_OFS = 8'h04;
  localparam logic [7:0] MFROUTE_F0_OFS = 8'h08;
  localparam logic [7:0] MFROUTE_F1_OFS = 8'h0C;
  localparam logic [7:0] DEVCTL_OFS = 8'h10;
  localparam logic [7:0] INTERRUPT_PIN_VALUE_F0_OFS = 8'h14;
  localparam logic [7:0] INTERRUPT_PIN_VALUE_F1_OFS = 8'h18;
  localparam logic [7:0] IRQSEL_OFS = 8'h1C;
  localparam logic [7:0] STATUS_OFS = 8'h20;

  // ==========================================================
  // system control fields
  localparam int unsigned TIE_BIT = 29;
  localparam int unsigned ROUTE_BIT = 26;
  localparam int unsigned PEND_BIT = 25;
  localparam int unsigned ENB_BIT = 24;
  localparam int unsigned HOLD_BIT = 1;

  // device control, irq select and status fields
  localparam int unsigned MODE_LSB = 1;
  localparam int unsigned SELA_LSB = 0;
  localparam int unsigned SELB_LSB = 4;
  localparam int unsigned FPCI_BIT = 8;
  localparam int unsigned STATUS_CHANGE_SIGNAL_MODE_BIT = 9;
  localparam int unsigned ST_INTA = 0;
  localparam int unsigned ST_INTB = 1;
  localparam int unsigned ST_IRQ2 = 2;
  localparam int unsigned ST_PEND_LSB = 3;
  localparam int unsigned ST_CLKRUN = 5;
  localparam int unsigned ST_SER = 6;

  // ==========================================================
  // signalling modes, in device control order
  typedef enum logic [1:0] {
    MODE_PAR_PCI,
    MODE_PAR_ISA,
    MODE_SER_ISA,
    MODE_SER_ALL
  } sig_mode_e;

  // terminal selector codes and terminal numbers
  localparam logic [3:0] SEL_CLKRUN = 4'h1;
  localparam logic [3:0] SEL_PCI = 4'h2;
  localparam logic [3:0] SEL_ISA_MIN = 4'h3;
  localparam int unsigned NUM_TERM = 7;
  localparam int unsigned TERM_INTA = 0;
  localparam int unsigned TERM_INTB = 1;
  localparam int unsigned TERM_IRQ2_LO = 3;
  localparam int unsigned TERM_IRQ2_HI = 6;
  localparam int unsigned TERM_CLKRUN = 6;
  localparam logic [3:0] IRQ2_NUM = 4'h2;

  // interrupt pin values and reset values
  localparam logic [7:0] INTERRUPT_PIN_VALUE_A = 8'h01;
  localparam logic [7:0] INTERRUPT_PIN_VALUE_B = 8'h02;
  localparam logic [27:0] MFROUTE_RST = 28'h0000000;
  localparam logic [9:0] IRQSEL_RST = 10'h000;

  // ==========================================================
  // serial frame layout and timing
  localparam logic [4:0] SLOT_LAST = 5'h14;
  localparam logic [1:0] PH_SAMPLE = 2'h0;
  localparam logic [1:0] PH_RECOV = 2'h1;
  localparam logic [1:0] PH_TURN = 2'h2;
  localparam int unsigned CLKRUN_DRIVE_CYC = 2;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic [1:0] card_irq;
    logic [1:0] card_status;
    logic [1:0] card_wake;
    logic [1:0] card_clock_run;
    logic [1:0] card_bus_req;
    logic [1:0] card_dma_req;
  } card_pins_s;

  typedef struct packed {
    logic legacy_busy;
    logic cb_master_busy;
    logic pci_master_busy;
    logic [1:0] cclk_running;
  } bridge_busy_s;

endpackage
